// ===== rtl/fdd_pkg.sv
// package for the fault detect and dispatch block
package fdd_pkg;
	// apb byte offsets
	localparam logic [11:0] OFF_AC = 12'h000;
	localparam logic [11:0] OFF_PC = 12'h004;
	localparam logic [11:0] OFF_TC = 12'h008;
	localparam logic [11:0] OFF_FCW = 12'h00C;
	localparam logic [11:0] OFF_IBP = 12'h010;
	localparam logic [11:0] OFF_DBP = 12'h014;
	localparam logic [11:0] OFF_BPEN = 12'h018;
	localparam logic [11:0] OFF_ETYPE = 12'h01C;
	localparam logic [11:0] OFF_FTIP = 12'h020;
	localparam logic [11:0] OFF_SPTIP = 12'h024;
	localparam logic [11:0] OFF_SSP = 12'h028;
	localparam logic [11:0] OFF_SYSTE = 12'h02C;
	localparam logic [11:0] OFF_SP = 12'h030;
	localparam logic [11:0] OFF_STAT = 12'h034;
	// field positions
	localparam int AC_OM = 3;
	localparam int AC_NIF = 4;
	localparam int PC_TE = 0;
	localparam int PC_SUP = 1;
	// reset values
	localparam logic [7:0] AC_RST = 8'h08;
	localparam logic [7:0] PC_RST = 8'h02;
	localparam logic [31:0] SP_RST = 32'h0000_0000;
	// fault types and subtypes
	localparam logic [7:0] FT_TRACE = 8'h01;
	localparam logic [7:0] FT_OPER = 8'h02;
	localparam logic [7:0] FT_ARITH = 8'h03;
	localparam logic [7:0] FT_CONSTR = 8'h05;
	localparam logic [7:0] FS_UNIMPL = 8'h02;
	localparam logic [7:0] FS_UNALIGN = 8'h03;
	localparam logic [7:0] FS_INVOPND = 8'h04;
	localparam logic [7:0] FS_RANGE = 8'h01;
	localparam logic [7:0] FS_IOVF = 8'h01;
	localparam logic [7:0] FS_TR_MARK = 8'h40;
	localparam logic [7:0] FS_TR_BP = 8'h80;
	// entry kinds, return code, limits
	localparam logic [1:0] EK_LOCAL = 2'h0;
	localparam logic [1:0] EK_SYSL = 2'h2;
	localparam logic [1:0] EK_SUPV = 2'h3;
	localparam logic [2:0] RT_FAULT = 3'h1;
	localparam logic [4:0] SFR_NUM = 5'h03;
	localparam logic [3:0] SYSCTL_NCMD = 4'h5;
	localparam logic [1:0] GRP_LONG = 2'h1;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_QUAD = 2'h3;
	localparam logic [31:0] FRAME_MASK = 32'h0000_003F;
	localparam logic [31:0] FRAME_BYTES = 32'h0000_0040;
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_CALL} fdd_fsm_t;
	// core events, all on the core clock
	typedef struct packed {
		logic exec;
		logic [31:0] ip;
		logic [1:0] grp;
		logic [4:0] rix;
		logic special_function_register;
		logic [4:0] sfx;
		logic mreq;
		logic [31:0] maddr;
		logic [1:0] msz;
		logic sysctl;
		logic [3:0] scmd;
		logic fdram;
		logic [7:0] tkind;
		logic fif;
		logic [2:0] fcond;
		logic mark;
		logic fmark;
		logic iovf;
		logic ret;
		logic ret_supv;
		logic [7:0] ret_ac;
		logic [7:0] ret_pc;
		logic processor_control_block_load;
	} fdd_evt_t;
	// whole block state
	typedef struct packed {
		fdd_fsm_t state;
		logic busy;
		logic [7:0] ac;
		logic [7:0] pc;
		logic [7:0] tc;
		logic fcw;
		logic umask;
		logic [31:0] ibp;
		logic [31:0] dbp;
		logic [1:0] bpen;
		logic [15:0] etype;
		logic [31:0] ft_ip;
		logic [31:0] spt_ip;
		logic [31:0] ssp;
		logic sys_te;
		logic [31:0] sp;
		logic [7:0] f_type;
		logic [7:0] f_sub;
		logic f_imp;
		logic [1:0] f_kind;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic call;
		logic [31:0] call_ip;
		logic [31:0] new_fp;
		logic [31:0] rec_addr;
		logic [7:0] rec_ac;
		logic [7:0] rec_pc;
		logic rip_valid;
		logic [2:0] pfp_rt;
	} fdd_st_t;
endpackage

// ===== rtl/fdd_top.sv
// fault detection, masking and handler dispatch with apb control registers
//
// Chosen here: register access over APB and the placing of the registers.
module fdd_top
	import fdd_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire fdd_evt_t I_EVT,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	output logic O_BUSY,
	output logic O_CALL,
	output logic [31:0] O_CALL_IP,
	output logic [31:0] O_NEW_FP,
	output logic [31:0] O_REC_ADDR,
	output logic [7:0] O_FAULT_TYPE,
	output logic [7:0] O_FAULT_SUB,
	output logic [7:0] O_REC_AC,
	output logic [7:0] O_REC_PC,
	output logic O_RIP_VALID,
	output logic [2:0] O_PFP_RT,
	output logic [7:0] O_AC,
	output logic [7:0] O_PC
);
	fdd_st_t s_reg; // all state
	fdd_st_t s_next; // next state
	fdd_evt_t e; // short alias of the event bundle
	logic reg_bad; // misaligned register group
	logic mem_bad; // misaligned memory request
	logic cond_ok; // fault-if condition met
	logic te; // trace enable from process controls
	logic mode_hit; // traced instruction kind
	logic bp_hit; // address breakpoint match
	logic mark_hit; // mark or forced mark
	logic hit; // some fault selected this cycle
	logic [7:0] ft; // selected type
	logic [7:0] fs; // selected subtype
	logic [1:0] kind; // entry kind of selected fault
	logic [31:0] base; // stack the frame is built on
	logic [31:0] new_frame_pointer; // aligned new frame pointer

	assign e = I_EVT;

	// condition detection from current-cycle core events and the control registers
	always_comb begin
		te = s_reg.pc[PC_TE];
		// long needs even start, triple and quad need multiple of four
		reg_bad = e.exec && ((e.grp == GRP_LONG && e.rix[0]) ||
			(e.grp > GRP_LONG && e.rix[1:0] != 2'h0));
		mem_bad = e.mreq && ((e.msz == SZ_HALF && e.maddr[0]) ||
			(e.msz == SZ_WORD && e.maddr[1:0] != 2'h0) ||
			(e.msz == SZ_QUAD && e.maddr[3:0] != 4'h0));
		// zero mask stands for the no-flags condition
		cond_ok = (e.fcond == 3'h0) ? (s_reg.ac[2:0] == 3'h0) :
			((e.fcond & s_reg.ac[2:0]) != 3'h0);
		mode_hit = te && e.exec && ((s_reg.tc & e.tkind) != 8'h00);
		bp_hit = te && ((s_reg.bpen[0] && e.exec && e.ip == s_reg.ibp) ||
			(s_reg.bpen[1] && e.mreq && e.maddr == s_reg.dbp));
		// forced mark traps even with tracing off
		mark_hit = e.fmark || (e.mark && te);
	end

	// priority select: at most one fault wins per cycle
	always_comb begin
		hit = 1'b1;
		ft = 8'h00;
		fs = 8'h00;
		if (e.fdram) begin
			ft = FT_OPER;
			fs = FS_UNIMPL;
		end else if (reg_bad) begin
			ft = FT_OPER;
			fs = FS_INVOPND;
		end else if (e.special_function_register && e.sfx >= SFR_NUM) begin
			ft = FT_OPER;
			fs = FS_INVOPND;
		end else if (e.sysctl && e.scmd >= SYSCTL_NCMD) begin
			ft = FT_OPER;
			fs = FS_INVOPND;
		end else if (mem_bad && !s_reg.umask) begin
			ft = FT_OPER;
			fs = FS_UNALIGN;
		end else if (e.fif && cond_ok) begin
			ft = FT_CONSTR;
			fs = FS_RANGE;
		end else if (e.iovf && !s_reg.ac[AC_OM]) begin
			ft = FT_ARITH;
			fs = FS_IOVF;
		end else if (mode_hit || bp_hit || mark_hit) begin
			// several trace causes merge into one subtype mask
			ft = FT_TRACE;
			fs = (mode_hit ? (s_reg.tc & e.tkind) : 8'h00) |
				(bp_hit ? FS_TR_BP : 8'h00) | (mark_hit ? FS_TR_MARK : 8'h00);
		end else begin
			hit = 1'b0;
		end
	end

	// next-state logic: bus slave, event capture, dispatch sequence
	always_comb begin
		s_next = s_reg;
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		s_next.call = 1'b0;
		kind = s_reg.etype[{s_reg.f_type[2:0], 1'b0} +: 2];
		base = s_reg.sp;
		new_frame_pointer = 32'h0000_0000;
		// apb access phase, answered one cycle later
		if (I_PSEL && I_PENABLE && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			if (I_PWRITE) begin
				case (I_PADDR)
					OFF_AC: s_next.ac = I_PWDATA[7:0];
					OFF_PC: s_next.pc = I_PWDATA[7:0];
					OFF_TC: s_next.tc = I_PWDATA[7:0];
					// staged only; takes effect at the next load
					OFF_FCW: s_next.fcw = I_PWDATA[0];
					OFF_IBP: s_next.ibp = I_PWDATA;
					OFF_DBP: s_next.dbp = I_PWDATA;
					OFF_BPEN: s_next.bpen = I_PWDATA[1:0];
					OFF_ETYPE: s_next.etype = I_PWDATA[15:0];
					OFF_FTIP: s_next.ft_ip = I_PWDATA;
					OFF_SPTIP: s_next.spt_ip = I_PWDATA;
					OFF_SSP: s_next.ssp = I_PWDATA;
					OFF_SYSTE: s_next.sys_te = I_PWDATA[0];
					OFF_SP: s_next.sp = I_PWDATA;
					OFF_STAT: s_next.pslverr = 1'b0; // read only, write ignored
					default: s_next.pslverr = 1'b1; // unmapped
				endcase
			end else begin
				case (I_PADDR)
					OFF_AC: s_next.prdata = {24'h000000, s_reg.ac};
					OFF_PC: s_next.prdata = {24'h000000, s_reg.pc};
					OFF_TC: s_next.prdata = {24'h000000, s_reg.tc};
					OFF_FCW: s_next.prdata = {31'h00000000, s_reg.fcw};
					OFF_IBP: s_next.prdata = s_reg.ibp;
					OFF_DBP: s_next.prdata = s_reg.dbp;
					OFF_BPEN: s_next.prdata = {30'h00000000, s_reg.bpen};
					OFF_ETYPE: s_next.prdata = {16'h0000, s_reg.etype};
					OFF_FTIP: s_next.prdata = s_reg.ft_ip;
					OFF_SPTIP: s_next.prdata = s_reg.spt_ip;
					OFF_SSP: s_next.prdata = s_reg.ssp;
					OFF_SYSTE: s_next.prdata = {31'h00000000, s_reg.sys_te};
					OFF_SP: s_next.prdata = s_reg.sp;
					OFF_STAT: s_next.prdata = {s_reg.f_type, s_reg.f_sub, 11'h000,
						s_reg.umask, s_reg.f_imp, s_reg.f_kind, s_reg.busy};
					default: s_next.pslverr = 1'b1;
				endcase
			end
		end
		// later software writes to the fault control word do not act until reload
		if (e.processor_control_block_load) begin
			s_next.umask = s_reg.fcw;
		end
		// dispatch sequence; the core holds off while busy
		case (s_reg.state)
			ST_IDLE: begin
				if (hit) begin
					s_next.f_type = ft;
					s_next.f_sub = fs;
					s_next.rec_ac = s_reg.ac;
					s_next.rec_pc = s_reg.pc;
					// without the bit, record ip of imprecise kinds is not usable
					s_next.f_imp = !s_reg.ac[AC_NIF] &&
						(ft == FT_OPER || ft == FT_ARITH || ft == FT_CONSTR);
					s_next.rip_valid = s_reg.ac[AC_NIF] ||
						!(ft == FT_OPER || ft == FT_ARITH || ft == FT_CONSTR);
					s_next.state = ST_SEL;
					s_next.busy = 1'b1;
				end else if (e.ret) begin
					s_next.ac = e.ret_ac;
					if (e.ret_supv && s_reg.pc[PC_SUP]) begin
						s_next.pc = e.ret_pc;
					end
				end
			end
			ST_SEL: begin
				s_next.f_kind = kind;
				if (kind == EK_SUPV && !s_reg.pc[PC_SUP]) begin
					base = s_reg.ssp;
					s_next.pc[PC_SUP] = 1'b1;
				end
				// otherwise the current stack is kept
				new_frame_pointer = (base + FRAME_MASK) & ~FRAME_MASK;
				s_next.new_fp = new_frame_pointer;
				s_next.rec_addr = new_frame_pointer - WORD_BYTES;
				s_next.sp = new_frame_pointer + FRAME_BYTES;
				// reserved code 01 is treated as a local entry
				if (kind == EK_SYSL || kind == EK_SUPV) begin
					s_next.call_ip = s_reg.spt_ip;
				end else begin
					s_next.call_ip = s_reg.ft_ip;
				end
				if (kind == EK_SUPV) begin
					s_next.pc[PC_TE] = (s_reg.f_type == FT_TRACE) ? 1'b0 : s_reg.sys_te;
				end
				s_next.pfp_rt = RT_FAULT;
				s_next.call = 1'b1;
				s_next.state = ST_CALL;
			end
			ST_CALL: begin
				s_next.state = ST_IDLE;
				s_next.busy = 1'b0;
			end
			default: begin
				s_next.state = ST_IDLE;
				s_next.busy = 1'b0;
			end
		endcase
	end

	// state register; constants only under reset
	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			s_reg <= '0;
			s_reg.state <= ST_IDLE;
			s_reg.ac <= AC_RST;
			s_reg.pc <= PC_RST;
			s_reg.sp <= SP_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs straight from the state flops
	assign O_PRDATA = s_reg.prdata;
	assign O_PREADY = s_reg.pready;
	assign O_PSLVERR = s_reg.pslverr;
	assign O_BUSY = s_reg.busy;
	assign O_CALL = s_reg.call;
	assign O_CALL_IP = s_reg.call_ip;
	assign O_NEW_FP = s_reg.new_fp;
	assign O_REC_ADDR = s_reg.rec_addr;
	assign O_FAULT_TYPE = s_reg.f_type;
	assign O_FAULT_SUB = s_reg.f_sub;
	assign O_REC_AC = s_reg.rec_ac;
	assign O_REC_PC = s_reg.rec_pc;
	assign O_RIP_VALID = s_reg.rip_valid;
	assign O_PFP_RT = s_reg.pfp_rt;
	assign O_AC = s_reg.ac;
	assign O_PC = s_reg.pc;

	// checks on the dispatch path
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);

	sequence sq_take;
		s_reg.state == ST_IDLE && hit;
	endsequence
	sequence sq_call;
		##2 O_CALL ##1 !O_CALL;
	endsequence

	a_fault_to_call: assert property (sq_take |-> sq_call)
		else $error("fault not dispatched in two cycles");
	a_dram_first: assert property (s_reg.state == ST_IDLE && e.fdram |=>
		O_FAULT_TYPE == FT_OPER && O_FAULT_SUB == FS_UNIMPL)
		else $error("data ram fetch not reported as unimplemented");
	a_sfr_range: assert property (s_reg.state == ST_IDLE && e.special_function_register && e.sfx >= SFR_NUM
		&& !e.fdram && !reg_bad |=> O_FAULT_SUB == FS_INVOPND && O_BUSY)
		else $error("bad special register not faulted");
	a_ovf_masked: assert property (s_reg.state == ST_IDLE && e.iovf && s_reg.ac[AC_OM]
		&& !e.fdram && !reg_bad && !e.special_function_register && !e.sysctl && !e.mreq && !e.fif
		&& !e.exec && !e.fmark |=> !O_BUSY)
		else $error("masked overflow raised a fault");
	a_rec_below: assert property (O_CALL |-> O_REC_ADDR == O_NEW_FP - WORD_BYTES
		&& O_PFP_RT == RT_FAULT)
		else $error("record not one word below frame");
	a_supv_enter: assert property (s_reg.state == ST_SEL && kind == EK_SUPV
		&& !s_reg.pc[PC_SUP] |=> O_PC[PC_SUP] && O_NEW_FP >= $past(s_reg.ssp))
		else $error("supervisor call did not switch mode");
	a_local_keep: assert property (s_reg.state == ST_SEL && kind != EK_SUPV |=>
		O_PC == $past(O_PC) && O_CALL)
		else $error("local call changed process controls");
	a_trace_clear: assert property (s_reg.state == ST_SEL && kind == EK_SUPV
		&& s_reg.f_type == FT_TRACE |=> !O_PC[PC_TE])
		else $error("trace enable kept on trace fault call");
	a_ret_user: assert property (s_reg.state == ST_IDLE && !hit && e.ret
		&& !s_reg.pc[PC_SUP] |=> O_PC == $past(O_PC))
		else $error("process controls restored outside supervisor");
	a_apb_answer: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
		else $error("apb access not answered");
endmodule

// ===== bench/fdd_core_model.sv
// core-side event source that faces the fault block
module fdd_core_model
	import fdd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_busy,
	output fdd_evt_t o_evt
);
	// quiet at time zero so the block sees no event during reset
	initial o_evt = '0;

	// one-cycle event; waits while the block is still dispatching
	task automatic send(input fdd_evt_t e);
		fdd_evt_t idle;
		int n;
		n = 0;
		@(posedge i_clk);
		while (i_busy === 1'b1 && n < 10) begin
			@(posedge i_clk);
			n++;
		end
		o_evt <= e;
		@(posedge i_clk);
		// strobes drop, data fields turn over so stale data cannot pass
		idle = ~e;
		idle.exec = 1'b0;
		idle.grp = '0;
		idle.special_function_register = 1'b0;
		idle.mreq = 1'b0;
		idle.sysctl = 1'b0;
		idle.fdram = 1'b0;
		idle.tkind = '0;
		idle.fif = 1'b0;
		idle.mark = 1'b0;
		idle.fmark = 1'b0;
		idle.iovf = 1'b0;
		idle.ret = 1'b0;
		idle.processor_control_block_load = 1'b0;
		o_evt <= idle;
	endtask
endmodule

// ===== bench/fdd_top_test.sv
// self-checking bench for the fault detect and dispatch block
module fdd_top_test
	import fdd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	fdd_evt_t evt;
	logic [31:0] prdata, call_ip, new_fp, rec_addr;
	logic pready, pslverr, busy, call, rip_valid;
	logic [7:0] ftype, fsub, rec_ac, rec_pc, ac, pc;
	logic [2:0] pfp_rt;
	int bad_count = 0;
	int n_tests = 0;
	logic [31:0] stk; // stack the next call should frame on
	logic [31:0] exp_ip; // handler ip the next call should use
	fdd_evt_t e;

	always #5 clk = ~clk;

	fdd_top fdd_top_i (.I_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_EVT(evt),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_BUSY(busy),
		.O_CALL(call), .O_CALL_IP(call_ip), .O_NEW_FP(new_fp), .O_REC_ADDR(rec_addr),
		.O_FAULT_TYPE(ftype), .O_FAULT_SUB(fsub), .O_REC_AC(rec_ac), .O_REC_PC(rec_pc),
		.O_RIP_VALID(rip_valid), .O_PFP_RT(pfp_rt), .O_AC(ac), .O_PC(pc));

	fdd_core_model fdd_core_model_i (.i_clk(clk), .i_busy(busy), .o_evt(evt));

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask

	// apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			bad_count++;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic er;
		apb(1'b1, a, d, q, er);
	endtask

	// sends one event and judges every call in the six cycles that follow it
	task automatic fchk(input fdd_evt_t ev, input int nc, input logic [7:0] ty, sb);
		logic [31:0] new_frame_pointer;
		int seen;
		new_frame_pointer = (stk + 32'h0000_003F) & ~32'h0000_003F;
		seen = 0;
		fdd_core_model_i.send(ev);
		repeat (6) begin
			@(posedge clk);
			if (call === 1'b1) begin
				seen++;
				chk("type", 32'(ty), 32'(ftype));
				chk("sub", 32'(sb), 32'(fsub));
				chk("ip", exp_ip, call_ip);
				chk("nfp", new_frame_pointer, new_fp);
				chk("rec", new_frame_pointer - 32'h0000_0004, rec_addr);
				chk("rt", 32'(RT_FAULT), 32'(pfp_rt));
				stk = new_frame_pointer + 32'h0000_0040;
			end
		end
		chk("calls", 32'(nc), 32'(seen));
	endtask

	task automatic t_regs;
		logic [31:0] q;
		logic er;
		chk("ac", 32'h0000_0008, 32'(ac));
		chk("pc", 32'h0000_0002, 32'(pc));
		wr(OFF_TC, 32'h0000_00A5);
		apb(1'b0, OFF_TC, '0, q, er);
		chk("tc", 32'h0000_00A5, q);
		apb(1'b0, 12'h0FC, '0, q, er);
		chk("slverr", 32'h0000_0001, 32'(er));
		wr(OFF_TC, '0);
	endtask

	task automatic t_oper;
		e = '0;
		e.fdram = 1'b1;
		fchk(e, 1, FT_OPER, FS_UNIMPL);
		chk("rip", '0, 32'(rip_valid));
		e = '0;
		e.exec = 1'b1;
		e.grp = GRP_LONG;
		e.rix = 5'h01;
		fchk(e, 1, FT_OPER, FS_INVOPND);
		e.rix = 5'h02;
		fchk(e, 0, '0, '0);
		e.grp = 2'h3;
		fchk(e, 1, FT_OPER, FS_INVOPND);
		e = '0;
		e.exec = 1'b1;
		e.special_function_register = 1'b1;
		e.sfx = 5'h03;
		fchk(e, 1, FT_OPER, FS_INVOPND);
		e.sfx = 5'h02;
		fchk(e, 0, '0, '0);
		e = '0;
		e.sysctl = 1'b1;
		e.scmd = SYSCTL_NCMD;
		fchk(e, 1, FT_OPER, FS_INVOPND);
		e.scmd = 4'h4;
		fchk(e, 0, '0, '0);
	endtask

	task automatic t_unal;
		fdd_evt_t f;
		e = '0;
		e.mreq = 1'b1;
		e.maddr = 32'h0000_0102;
		e.msz = SZ_HALF;
		fchk(e, 0, '0, '0);
		e.msz = SZ_WORD;
		fchk(e, 1, FT_OPER, FS_UNALIGN);
		wr(OFF_FCW, 32'h0000_0001);
		fchk(e, 1, FT_OPER, FS_UNALIGN);
		f = '0;
		f.processor_control_block_load = 1'b1;
		fchk(f, 0, '0, '0);
		fchk(e, 0, '0, '0);
	endtask

	task automatic t_arith;
		e = '0;
		e.iovf = 1'b1;
		fchk(e, 0, '0, '0);
		wr(OFF_AC, 32'h0000_0012);
		fchk(e, 1, FT_ARITH, FS_IOVF);
		chk("rip", 32'h0000_0001, 32'(rip_valid));
		chk("rec_ac", 32'h0000_0012, 32'(rec_ac));
		chk("rec_pc", 32'h0000_0002, 32'(rec_pc));
		e = '0;
		e.fif = 1'b1;
		e.fcond = 3'h2;
		fchk(e, 1, FT_CONSTR, FS_RANGE);
		e.fcond = 3'h5;
		fchk(e, 0, '0, '0);
		wr(OFF_AC, '0);
		e.fcond = 3'h0;
		fchk(e, 1, FT_CONSTR, FS_RANGE);
		chk("rip", '0, 32'(rip_valid));
	endtask

	task automatic t_trace;
		wr(OFF_TC, 32'h0000_0004);
		e = '0;
		e.exec = 1'b1;
		e.tkind = 8'h04;
		fchk(e, 0, '0, '0);
		wr(OFF_PC, 32'h0000_0003);
		fchk(e, 1, FT_TRACE, 8'h04);
		e.tkind = 8'h02;
		fchk(e, 0, '0, '0);
		e = '0;
		e.mark = 1'b1;
		fchk(e, 1, FT_TRACE, FS_TR_MARK);
		wr(OFF_IBP, 32'h0000_0800);
		wr(OFF_BPEN, 32'h0000_0001);
		e = '0;
		e.exec = 1'b1;
		e.ip = 32'h0000_0800;
		fchk(e, 1, FT_TRACE, FS_TR_BP);
		e.ip = 32'h0000_0804;
		fchk(e, 0, '0, '0);
		wr(OFF_BPEN, '0);
		wr(OFF_PC, 32'h0000_0002);
		e = '0;
		e.fmark = 1'b1;
		fchk(e, 1, FT_TRACE, FS_TR_MARK);
	endtask

	task automatic t_ret;
		e = '0;
		e.ret = 1'b1;
		e.ret_ac = 8'h11;
		fchk(e, 0, '0, '0);
		chk("ac", 32'h0000_0011, 32'(ac));
		chk("pc", 32'h0000_0002, 32'(pc));
		e.ret_supv = 1'b1;
		e.ret_pc = 8'h03;
		fchk(e, 0, '0, '0);
		chk("pc", 32'h0000_0003, 32'(pc));
		wr(OFF_PC, '0);
		fchk(e, 0, '0, '0);
		chk("pc", '0, 32'(pc));
	endtask

	task automatic t_prio;
		e = '0;
		e.fdram = 1'b1;
		e.exec = 1'b1;
		e.special_function_register = 1'b1;
		e.sfx = 5'h07;
		e.mark = 1'b1;
		fchk(e, 1, FT_OPER, FS_UNIMPL);
		e.fdram = 1'b0;
		fchk(e, 1, FT_OPER, FS_INVOPND);
	endtask

	task automatic t_sys;
		exp_ip = 32'h0000_2000;
		wr(OFF_ETYPE, 32'h0000_0020);
		e = '0;
		e.fdram = 1'b1;
		fchk(e, 1, FT_OPER, FS_UNIMPL);
		wr(OFF_ETYPE, 32'h0000_003C);
		wr(OFF_SSP, 32'h0000_1000);
		wr(OFF_SYSTE, 32'h0000_0001);
		stk = 32'h0000_1000;
		fchk(e, 1, FT_OPER, FS_UNIMPL);
		chk("pc", 32'h0000_0003, 32'(pc));
		e = '0;
		e.fmark = 1'b1;
		fchk(e, 1, FT_TRACE, FS_TR_MARK);
		chk("pc", 32'h0000_0002, 32'(pc));
	endtask

	// watchdog: the whole run needs a few hundred cycles
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		wr(OFF_SP, 32'h0000_0105);
		wr(OFF_FTIP, 32'h0000_0400);
		wr(OFF_SPTIP, 32'h0000_2000);
		stk = 32'h0000_0105;
		exp_ip = 32'h0000_0400;
		t_oper();
		t_unal();
		t_arith();
		t_trace();
		t_ret();
		t_prio();
		t_sys();
		complete_run();
	end
endmodule
